/* fgl_regs.svh */
`ifndef FGL_REGS_SVH
`define FGL_REGS_SVH

// ==========================================================
// Opcodes
`define FGL_OP_WREN 8'h06
`define FGL_OP_GLOCK 8'h7e
`define FGL_OP_GUNLOCK 8'h98
`define FGL_OP_RST_EN 8'h66
`define FGL_OP_RST 8'h99

// ==========================================================
// Register byte offsets
`define FGL_OFS_CONFIG 4'h0
`define FGL_OFS_STATUS 4'h4
`define FGL_OFS_LOCKS 4'h8
`define FGL_OFS_PROTECT 4'hc

// ==========================================================
// Config field positions
`define FGL_CFG_SCHEME 0
`define FGL_CFG_SUSPEND 1
`define FGL_CFG_BP_LO 4
`define FGL_CFG_BP_HI 6
`define FGL_CFG_WRAP_LO 8
`define FGL_CFG_WRAP_HI 10
`define FGL_CFG_PARAM_LO 16
`define FGL_CFG_PARAM_HI 23

// Status field positions
`define FGL_ST_BUSY 0
`define FGL_ST_WEL 1
`define FGL_ST_SUSPEND 2
`define FGL_ST_RST_EN 3
`define FGL_ST_RECOVER 4

// ==========================================================
// Reset values
`define FGL_CONFIG_RST 32'h0000_0000

// ==========================================================
// Timing
`define FGL_T_RST_NS 30000
`define FGL_CLK_MHZ 50
`define FGL_RST_CYCLES ((`FGL_T_RST_NS * `FGL_CLK_MHZ + 999) / 1000)

`endif

/* fgl_pkg.sv */
package fgl_pkg;
   // Command sequencer states, one-hot
   typedef enum logic [2:0] {
      FGL_IDLE = 3'b001,
      FGL_ARMED = 3'b010,
      FGL_RECOVER = 3'b100
   } fgl_state_e;
endpackage

/* fgl_cmd_if.sv */
interface fgl_cmd_if;
   logic valid;
   logic [7:0] opcode;
   modport src (output valid, output opcode);
   modport dst (input valid, input opcode);
endinterface

/* fgl_spi_rx.sv */
module fgl_spi_rx (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial pins from the host
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   // Received one-byte command
   fgl_cmd_if.src cmd
);
   // ==========================================================
   // Pin synchronisers and filtered levels
   logic [2:0] cs_sy, ck_sy, di_sy;
   logic cs_f, ck_f, di_f;
   logic next_cs_f, next_ck_f, next_di_f;
   logic [7:0] shift, next_shift;
   logic [3:0] cnt, next_cnt;
   logic [7:0] op, next_op;
   logic vld, next_vld;
   logic ck_rise, cs_rise;

   assign cmd.valid = vld;
   assign cmd.opcode = op;

   // A level only counts once the second and third stages agree
   always_comb begin
      next_cs_f = (cs_sy[1] == cs_sy[2]) ? cs_sy[2] : cs_f;
      next_ck_f = (ck_sy[1] == ck_sy[2]) ? ck_sy[2] : ck_f;
      next_di_f = (di_sy[1] == di_sy[2]) ? di_sy[2] : di_f;
      ck_rise = ~ck_f & next_ck_f;
      cs_rise = ~cs_f & next_cs_f;
      next_shift = shift;
      next_cnt = cnt;
      next_op = op;
      next_vld = 1'b0;
      if (cs_f) begin
         next_cnt = 4'h0;
      end else if (cs_rise) begin
         // Only a frame of exactly eight bits is a command
         next_vld = (cnt == 4'h8);
         next_op = shift;
         next_cnt = 4'h0;
      end else if (ck_rise) begin
         // Bits taken on rising serial clock, MSB first
         next_shift = {shift[6:0], next_di_f};
         next_cnt = (cnt == 4'h9) ? cnt : cnt + 4'h1;
      end
   end

   // Registers; data sync delay matches clock sync delay
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cs_sy <= 3'h7;
         ck_sy <= 3'h0;
         di_sy <= 3'h0;
         cs_f <= 1'b1;
         ck_f <= 1'b0;
         di_f <= 1'b0;
         shift <= 8'h00;
         cnt <= 4'h0;
         op <= 8'h00;
         vld <= 1'b0;
      end else begin
         cs_sy <= {cs_sy[1:0], cs_n};
         ck_sy <= {ck_sy[1:0], sclk};
         di_sy <= {di_sy[1:0], mosi};
         cs_f <= next_cs_f;
         ck_f <= next_ck_f;
         di_f <= next_di_f;
         shift <= next_shift;
         cnt <= next_cnt;
         op <= next_op;
         vld <= next_vld;
      end
   end
endmodule

/* fgl_top.sv */
`include "fgl_regs.svh"

module fgl_top
   import fgl_pkg::*;
#(
   parameter int NUM_LOCKS = 16,
   parameter int RECOVER_CYCLES = `FGL_RST_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   // Array engine
   input wire logic op_busy,
   output logic abort_op,
   output logic [NUM_LOCKS-1:0] protect_map,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   // ==========================================================
   // Command receiver
   fgl_cmd_if cmd_bus ();

   fgl_spi_rx u_rx (
      .clk(clk),
      .rst_n(rst_n),
      .cs_n(cs_n),
      .sclk(sclk),
      .mosi(mosi),
      .cmd(cmd_bus)
   );

   // ==========================================================
   // State
   fgl_state_e state, next_state;
   logic [10:0] rcnt, next_rcnt;
   logic write_enable_latch, next_wel;
   logic [NUM_LOCKS-1:0] locks, next_locks;
   logic [31:0] config_r, next_config;
   logic abort, next_abort;
   logic [NUM_LOCKS-1:0] prot, next_prot;
   logic ack, next_ack;
   logic [31:0] rdata, next_rdata;
   logic cmd_ok, do_reset, reg_wr;

   // Block-protect field: a nonzero value k protects the top 2^(k-1)/64 of blocks
   function automatic logic [NUM_LOCKS-1:0] bp_decode(input logic [2:0] bp);
      logic [NUM_LOCKS-1:0] m;
      m = '0;
      for (int i = 0; i < NUM_LOCKS; i++) begin
         if (bp != 3'h0 && (NUM_LOCKS - i) * 64 <= (1 << (bp - 3'h1)) * NUM_LOCKS) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   assign abort_op = abort;
   assign protect_map = prot;
   assign avs_readdata = rdata;
   // One wait cycle per access, then the answer
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;

   // ==========================================================
   // Command sequencer
   always_comb begin
      cmd_ok = cmd_bus.valid & (state != FGL_RECOVER);
      do_reset = cmd_ok & (state == FGL_ARMED) & (cmd_bus.opcode == `FGL_OP_RST);
      // Write lands at the edge where waitrequest is seen low, as the master expects
      reg_wr = avs_write & ack & (avs_address == `FGL_OFS_CONFIG);
      next_state = state;
      next_rcnt = rcnt;
      next_wel = write_enable_latch;
      next_locks = locks;
      next_config = config_r;
      next_abort = 1'b0;
      if (reg_wr) begin
         next_config = avs_writedata & 32'h00ff_0773;
      end
      unique case (state)
         FGL_IDLE: begin
            if (cmd_ok && cmd_bus.opcode == `FGL_OP_RST_EN) begin
               next_state = FGL_ARMED;
            end
         end
         FGL_ARMED: begin
            // Anything but reset disarms; reset-enable again stays armed
            if (cmd_ok && cmd_bus.opcode != `FGL_OP_RST_EN) begin
               next_state = FGL_IDLE;
            end
         end
         FGL_RECOVER: begin
            if (rcnt == 11'h001) begin
               next_state = FGL_IDLE;
            end
            next_rcnt = rcnt - 11'h001;
         end
      endcase
      if (cmd_ok) begin
         if (cmd_bus.opcode == `FGL_OP_WREN) begin
            next_wel = 1'b1;
         end
         if (cmd_bus.opcode == `FGL_OP_GLOCK && write_enable_latch) begin
            next_locks = '1;
         end
         if (cmd_bus.opcode == `FGL_OP_GUNLOCK && write_enable_latch) begin
            next_locks = '0;
         end
      end
      if (do_reset) begin
         // Volatile state back to power-on; reset outranks a register write
         next_state = FGL_RECOVER;
         next_rcnt = RECOVER_CYCLES[10:0];
         next_wel = 1'b0;
         next_locks = '1;
         next_config = `FGL_CONFIG_RST;
         next_abort = 1'b1;
      end
      // Effective protection follows the selected scheme
      next_prot = next_config[`FGL_CFG_SCHEME] ? next_locks :
                  bp_decode(next_config[`FGL_CFG_BP_HI:`FGL_CFG_BP_LO]);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= FGL_IDLE;
         rcnt <= 11'h000;
         write_enable_latch <= 1'b0;
         locks <= '1;
         config_r <= `FGL_CONFIG_RST;
         abort <= 1'b0;
         prot <= '0;
      end else begin
         state <= next_state;
         rcnt <= next_rcnt;
         write_enable_latch <= next_wel;
         locks <= next_locks;
         config_r <= next_config;
         abort <= next_abort;
         prot <= next_prot;
      end
   end

   // ==========================================================
   // Bus read path; unmapped reads return zero
   always_comb begin
      next_ack = (avs_read | avs_write) & ~ack;
      next_rdata = rdata;
      if (avs_read && !ack) begin
         unique case (avs_address)
            `FGL_OFS_CONFIG: next_rdata = config_r;
            `FGL_OFS_STATUS: next_rdata = {27'h0, state == FGL_RECOVER, state == FGL_ARMED,
                                          config_r[`FGL_CFG_SUSPEND], write_enable_latch, op_busy};
            `FGL_OFS_LOCKS: next_rdata = 32'(locks);
            `FGL_OFS_PROTECT: next_rdata = 32'(prot);
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end
endmodule

/* fgl_host_bfm.sv */
module fgl_host_bfm (
   // Clock
   input wire logic clk,
   // Serial pins to the device
   output logic cs_n,
   output logic sclk,
   output logic mosi
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Idle: deselected, serial clock parked low between frames
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // Half of a 160 ns serial clock period
   task automatic hold();
      repeat (4) @(posedge clk);
   endtask
   // One frame, MSB first; fewer than eight bits makes a short frame on purpose
   task automatic frame(input logic [7:0] op, input int nb);
      @(posedge clk);
      cs_n <= 1'b0;
      hold();
      for (int i = 0; i < nb; i++) begin
         mosi <= op[7-i];
         hold();
         sclk <= 1'b1;
         hold();
         sclk <= 1'b0;
      end
      hold();
      cs_n <= 1'b1;
      // Released data line flips so a stale bit cannot pass for a driven one
      mosi <= ~mosi;
      hold();
      hold();
   endtask
endmodule

/* fgl_top_chk.sv */
module fgl_top_chk #(
   parameter int NUM_LOCKS = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial and bus pins
   input wire logic cs_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_address,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Array side
   input wire logic abort_op,
   input wire logic [NUM_LOCKS-1:0] protect_map
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Bus steps
   wire logic req = avs_read | avs_write;
   sequence s_answer;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   sequence s_cfg_clear;
      avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_writedata[6:0] == 7'h00;
   endsequence
   sequence s_st_rd;
      avs_read && !avs_waitrequest && avs_address == 4'h4;
   endsequence
   // ==========================================================
   // Properties
   AST_ABORT_PULSE: assert property (abort_op |=> !abort_op [*8])
      else $error("abort repeated inside recovery");
   AST_ABORT_FRAME: assert property (abort_op |-> cs_n && $past(cs_n, 2))
      else $error("abort without a closed frame");
   AST_ABORT_PROT: assert property (abort_op |-> ##[1:3] protect_map == '0)
      else $error("protection not back to power-on state");
   AST_SCHEME_OFF: assert property (s_cfg_clear |-> ##[1:2] protect_map == '0)
      else $error("lock bits protect with scheme off");
   AST_RECOVER_ST: assert property (s_st_rd and avs_readdata[4] |-> !avs_readdata[3] && !avs_readdata[1])
      else $error("command taken during recovery");
   AST_WAIT_ONE: assert property ($rose(req) |-> s_answer)
      else $error("bus answer not after one wait");
   AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == '0)
      else $error("unmapped read not zero");
   AST_CFG_RSVD: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0
      |-> (avs_readdata & 32'hff00_f88c) == '0)
      else $error("reserved config bits set");
endmodule

bind fgl_top fgl_top_chk #(.NUM_LOCKS(NUM_LOCKS)) u_fgl_top_chk (
   .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .avs_read(avs_read), .avs_write(avs_write),
   .avs_address(avs_address), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .abort_op(abort_op), .protect_map(protect_map));

/* fgl_top_tb_top.sv */
module fgl_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, op_busy, avs_read, avs_write, avs_waitrequest, abort_op, cs_n, sclk, mosi;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [15:0] protect_map;
   int error_cnt = 0;
   int comparisons = 0;
   int aborts = 0;
   fgl_host_bfm u_fgl_host_bfm (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
   // Short recovery keeps the run brief
   fgl_top #(.NUM_LOCKS(16), .RECOVER_CYCLES(200)) u_fgl_top (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
      .sclk(sclk), .mosi(mosi), .op_busy(op_busy), .abort_op(abort_op), .protect_map(protect_map),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   // ==========================================================
   // Clock, abort counter, watchdog
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) if (abort_op === 1'b1) aborts++;
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is seen low at a rising edge
   // Only the watchdog ends a wait that never gets its answer
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rc(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, rd);
      chk(rd, e);
   endtask
   task automatic cmd(input logic [7:0] op);
      u_fgl_host_bfm.frame(op, 8);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_power();
      rc(4'h8, 32'h0000_ffff);
      bus(1'b1, 4'h8, 32'h0, rd);
      rc(4'h8, 32'h0000_ffff);
      rc(4'h1, 32'h0);
      op_busy <= 1'b1;
      rc(4'h4, 32'h1);
      op_busy <= 1'b0;
      $display("t_power done");
   endtask
   task automatic t_lock();
      bus(1'b1, 4'h0, 32'h0, rd);
      rc(4'hc, 32'h0);
      cmd(8'h98);
      rc(4'h8, 32'h0000_ffff);
      cmd(8'h06);
      cmd(8'h98);
      rc(4'h8, 32'h0);
      bus(1'b1, 4'h0, 32'h1, rd);
      rc(4'hc, 32'h0);
      u_fgl_host_bfm.frame(8'h7e, 7);
      rc(4'h8, 32'h0);
      cmd(8'h7e);
      rc(4'h8, 32'h0000_ffff);
      rc(4'hc, 32'h0000_ffff);
      chk(32'(protect_map), 32'h0000_ffff);
      // Scheme off, block-protect 5: top quarter of sixteen blocks
      bus(1'b1, 4'h0, 32'h0000_0050, rd);
      rc(4'hc, 32'h0000_f000);
      chk(32'(protect_map), 32'h0000_f000);
      $display("t_lock done");
   endtask
   task automatic t_reset();
      int n;
      bus(1'b1, 4'h0, 32'h00ff_0701, rd);
      cmd(8'h98);
      rc(4'h4, 32'h2);
      cmd(8'h66);
      cmd(8'h06);
      cmd(8'h99);
      rc(4'h0, 32'h00ff_0701);
      n = aborts;
      cmd(8'h66);
      cmd(8'h99);
      chk(32'(aborts - n), 32'h1);
      rc(4'h4, 32'h10);
      rc(4'h0, 32'h0);
      rc(4'h8, 32'h0000_ffff);
      cmd(8'h06);
      rc(4'h4, 32'h10);
      repeat (200) @(posedge clk);
      cmd(8'h06);
      rc(4'h4, 32'h2);
      $display("t_reset done");
   endtask
   // Hardware reset in mid-run brings the volatile state back as well
   task automatic t_rerst();
      cmd(8'h98);
      rc(4'h8, 32'h0);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      rc(4'h8, 32'h0000_ffff);
      rc(4'h4, 32'h0);
      $display("t_rerst done");
   endtask
   task automatic end_sim();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      op_busy = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      t_power();
      t_lock();
      t_reset();
      t_rerst();
      end_sim();
   end
endmodule
